// ---- csp_pkg.sv ----
// Constants, encodings and carrier types for the core status and pointer regs
package csp_pkg;

   // Special-function-register addresses
   localparam logic [7:0] SFR_STACK_ADDR  = 8'h81;
   localparam logic [7:0] SFR_DATA_POINTER_PAIR_LO     = 8'h82;
   localparam logic [7:0] SFR_DATA_POINTER_PAIR_HI     = 8'h83;
   localparam logic [7:0] SFR_STATUS_ADDR = 8'hd0;

   // Reset values
   localparam logic [7:0] STACK_RESET     = 8'h07;
   localparam logic [7:0] DATA_POINTER_PAIR_LO_RESET   = 8'h00;
   localparam logic [7:0] DATA_POINTER_PAIR_HI_RESET   = 8'h00;
   localparam logic [7:0] STATUS_RESET    = 8'h00;
   localparam logic [7:0] UNMAPPED_READ   = 8'h00;

   // Stack step and register-bank geometry (eight bytes per bank)
   localparam logic [7:0] STACK_STEP      = 8'h01;
   localparam logic [2:0] BANK_OFFSET     = 3'h0;

   // Nibble and byte limits used by the flag logic and the add carry check
   localparam logic [4:0] NIBBLE_MAX      = 5'h0f;
   localparam logic [8:0] BYTE_MAX        = 9'h0ff;
   localparam logic [15:0] PRODUCT_MAX    = 16'h00ff;

   // Status byte layout, bit 7 down to bit 0
   typedef struct packed {
      logic       carry_flag;
      logic       nibble_carry_flag;
      logic       user_flag_zero;
      logic       bank_select_high;
      logic       bank_select_low;
      logic       arith_excess_flag;
      logic       user_flag_one;
      logic       parity;
   } csp_status_t;

   // Arithmetic operations that touch the flags
   typedef enum logic [2:0] {
      CSP_OP_ADD  = 3'b000,
      CSP_OP_ADDC = 3'b001,
      CSP_OP_SUBB = 3'b010,
      CSP_OP_MUL  = 3'b011,
      CSP_OP_DIV  = 3'b100
   } csp_arith_op_t;

   // Flags produced by one arithmetic operation
   typedef struct packed {
      logic       carry_flag;
      logic       nibble_carry_flag;
      logic       arith_excess_flag;
   } csp_arith_flags_t;

   // Whole register state of the block
   typedef struct packed {
      logic [7:0]  stack_top_pointer;
      logic [7:0]  stack_addr;
      logic [7:0]  data_pointer_low;
      logic [7:0]  data_pointer_high;
      csp_status_t status;
      logic [4:0]  bank_base;
      logic [7:0]  rdata;
   } csp_state_t;

endpackage : csp_pkg

// ---- csp_flag_calc.sv ----
// Carry, nibble-carry and overflow evaluation for one arithmetic operation
`timescale 1ns/1ps
module csp_flag_calc (
   // Operation and operands
   input  wire csp_pkg::csp_arith_op_t op_i,
   input  wire logic [7:0]             a_i,
   input  wire logic [7:0]             b_i,
   input  wire logic                   carry_i,
   // Resulting flags
   output csp_pkg::csp_arith_flags_t   flags_o
);

   logic       cin;
   logic [8:0] sum;
   logic [8:0] diff;
   logic [4:0] nib_sum;
   logic [4:0] nib_sub;
   logic [15:0] product;

   // Carry-in only counts for the with-carry and with-borrow forms
   always_comb begin
      cin     = (op_i == csp_pkg::CSP_OP_ADDC || op_i == csp_pkg::CSP_OP_SUBB)
                ? carry_i : 1'b0;
      sum     = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin};
      diff    = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin};
      nib_sum = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin};
      nib_sub = {1'b0, b_i[3:0]} + {4'h0, cin};
      product = a_i * b_i;
   end

   // Flag selection; multiply and divide never carry
   always_comb begin
      flags_o = '0;
      case (op_i)
         csp_pkg::CSP_OP_ADD, csp_pkg::CSP_OP_ADDC: begin
            flags_o.carry_flag        = sum[8];
            flags_o.nibble_carry_flag = nib_sum > csp_pkg::NIBBLE_MAX;
            flags_o.arith_excess_flag = (a_i[7] == b_i[7]) && (sum[7] != a_i[7]);
         end
         csp_pkg::CSP_OP_SUBB: begin
            flags_o.carry_flag        = diff[8];
            flags_o.nibble_carry_flag = {1'b0, a_i[3:0]} < nib_sub;
            flags_o.arith_excess_flag = (a_i[7] != b_i[7]) && (diff[7] != a_i[7]);
         end
         csp_pkg::CSP_OP_MUL: begin
            flags_o.arith_excess_flag = product > csp_pkg::PRODUCT_MAX;
         end
         csp_pkg::CSP_OP_DIV: begin
            flags_o.arith_excess_flag = (b_i == 8'h00);
         end
         default: begin
            flags_o = '0;
         end
      endcase
   end

endmodule : csp_flag_calc

// ---- csp_core_regs.sv ----
// Stack pointer, data pointer pair and program status byte of the core
//
// Contract
// - Stack pointer reads 0x07 after reset.
// - Stack pointer marks stack top; it increments before each push write.
// - Low and high data pointer bytes join as one 16-bit program address.
// - Carry flag bit 7 follows add carry or subtract borrow, else cleared.
// - Bit 6 follows carry into or borrow from upper nibble, else cleared.
// - Bits 5 and 1 are user flags changed only by software.
// - Bits 4..3 pick bank at 0x00, 0x08, 0x10 or 0x18.
// - Overflow bit 2 set on signed overflow of add, add-carry, subtract.
// - Overflow set when a multiply product exceeds 255.
// - Overflow set when dividing by zero.
// - These five operations clear overflow when no overflow occurs.
// - Read-only bit 0 is odd parity of the accumulator.
// - Each bank is eight consecutive bytes; only one bank active.
`timescale 1ns/1ps
module csp_core_regs (
   // Clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   rst_n_i,
   // Special-function-register access from the core
   input  wire logic [7:0]             sfr_addr_i,
   input  wire logic                   sfr_wr_i,
   input  wire logic [7:0]             sfr_wdata_i,
   input  wire logic                   sfr_rd_i,
   output logic [7:0]                  sfr_rdata_o,
   // Arithmetic flag update
   input  wire logic                   alu_valid_i,
   input  wire csp_pkg::csp_arith_op_t alu_op_i,
   input  wire logic [7:0]             alu_a_i,
   input  wire logic [7:0]             alu_b_i,
   input  wire logic [7:0]             acc_i,
   // Stack operations
   input  wire logic                   push_i,
   input  wire logic                   pop_i,
   output logic [7:0]                  stack_addr_o,
   output logic [7:0]                  stack_ptr_o,
   // Pointers and status
   output logic [15:0]                 data_pointer_o,
   output logic [4:0]                  bank_base_o,
   output csp_pkg::csp_status_t        status_o
);

   csp_pkg::csp_state_t       s;
   csp_pkg::csp_state_t       next_s;
   csp_pkg::csp_arith_flags_t arith_flags;
   csp_pkg::csp_status_t      wr_status;

   // Flag evaluation against the carry currently held
   csp_flag_calc u_flags (
      .op_i    (alu_op_i),
      .a_i     (alu_a_i),
      .b_i     (alu_b_i),
      .carry_i (s.status.carry_flag),
      .flags_o (arith_flags)
   );

   assign wr_status = csp_pkg::csp_status_t'(sfr_wdata_i);

   // Next-state logic; later steps override earlier ones
   always_comb begin
      next_s = s;
      // Pre-increment push, post-decrement pop
      if (push_i) begin
         next_s.stack_top_pointer = s.stack_top_pointer + csp_pkg::STACK_STEP;
         next_s.stack_addr        = s.stack_top_pointer + csp_pkg::STACK_STEP;
      end else if (pop_i) begin
         next_s.stack_addr        = s.stack_top_pointer;
         next_s.stack_top_pointer = s.stack_top_pointer - csp_pkg::STACK_STEP;
      end
      // Software writes win over a same-cycle stack step
      if (sfr_wr_i) begin
         case (sfr_addr_i)
            csp_pkg::SFR_STACK_ADDR: begin
               next_s.stack_top_pointer = sfr_wdata_i;
            end
            csp_pkg::SFR_DATA_POINTER_PAIR_LO: begin
               next_s.data_pointer_low = sfr_wdata_i;
            end
            csp_pkg::SFR_DATA_POINTER_PAIR_HI: begin
               next_s.data_pointer_high = sfr_wdata_i;
            end
            csp_pkg::SFR_STATUS_ADDR: begin
               next_s.status        = wr_status;
               next_s.status.parity = s.status.parity;
            end
            default: begin
               next_s.rdata = s.rdata;
            end
         endcase
      end
      // Hardware flag results win over a same-cycle status write
      if (alu_valid_i) begin
         next_s.status.carry_flag        = arith_flags.carry_flag;
         next_s.status.nibble_carry_flag =
            arith_flags.nibble_carry_flag;
         next_s.status.arith_excess_flag =
            arith_flags.arith_excess_flag;
      end
      // Parity is not writable; it lags the accumulator by one cycle
      next_s.status.parity = ^acc_i;
      // One eight-byte bank at a time
      next_s.bank_base = {next_s.status.bank_select_high,
                          next_s.status.bank_select_low,
                          csp_pkg::BANK_OFFSET};
      // Read data shows values held before this access
      if (sfr_rd_i) begin
         case (sfr_addr_i)
            csp_pkg::SFR_STACK_ADDR:  next_s.rdata = s.stack_top_pointer;
            csp_pkg::SFR_DATA_POINTER_PAIR_LO:     next_s.rdata = s.data_pointer_low;
            csp_pkg::SFR_DATA_POINTER_PAIR_HI:     next_s.rdata = s.data_pointer_high;
            csp_pkg::SFR_STATUS_ADDR: next_s.rdata = s.status;
            default:                  next_s.rdata = csp_pkg::UNMAPPED_READ;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s.stack_top_pointer <= csp_pkg::STACK_RESET;
         s.stack_addr        <= csp_pkg::STACK_RESET;
         s.data_pointer_low  <= csp_pkg::DATA_POINTER_PAIR_LO_RESET;
         s.data_pointer_high <= csp_pkg::DATA_POINTER_PAIR_HI_RESET;
         s.status            <= csp_pkg::STATUS_RESET;
         s.bank_base         <= 5'h00;
         s.rdata             <= csp_pkg::UNMAPPED_READ;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state flops
   assign sfr_rdata_o    = s.rdata;
   assign stack_addr_o   = s.stack_addr;
   assign stack_ptr_o    = s.stack_top_pointer;
   assign data_pointer_o = {s.data_pointer_high, s.data_pointer_low};
   assign bank_base_o    = s.bank_base;
   assign status_o       = s.status;

   // Helper terms for the checks below
   logic quiet_sfr;
   logic [8:0] chk_sum;
   logic [15:0] chk_prod;
   assign quiet_sfr = !(sfr_wr_i && sfr_addr_i == csp_pkg::SFR_STATUS_ADDR);
   assign chk_sum   = {1'b0, alu_a_i} + {1'b0, alu_b_i};
   assign chk_prod  = alu_a_i * alu_b_i;

   sequence push_only_s;
      push_i && !(sfr_wr_i && sfr_addr_i == csp_pkg::SFR_STACK_ADDR);
   endsequence

   sequence push_lands_s;
      (stack_ptr_o == $past(stack_ptr_o) + 8'h01) &&
      (stack_addr_o == stack_ptr_o);
   endsequence

   sp_reset_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> stack_ptr_o == 8'h07)
      else $error("stack pointer not 0x07 after reset");

   push_incr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      push_only_s |=> push_lands_s)
      else $error("push did not pre-increment stack pointer");

   data_pointer_pair_pair_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (sfr_wr_i && sfr_addr_i == csp_pkg::SFR_DATA_POINTER_PAIR_HI) ##1 !sfr_wr_i
      |-> data_pointer_o[15:8] == $past(sfr_wdata_i) &&
          data_pointer_o[7:0] == $past(data_pointer_o[7:0]))
      else $error("data pointer high byte not joined");

   add_carry_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      alu_valid_i && alu_op_i == csp_pkg::CSP_OP_ADD
      |=> status_o.carry_flag == $past(chk_sum > csp_pkg::BYTE_MAX))
      else $error("carry flag wrong after add");

   nibble_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      alu_valid_i && alu_op_i == csp_pkg::CSP_OP_ADD
      |=> status_o.nibble_carry_flag ==
          $past(({1'b0, alu_a_i[3:0]} + {1'b0, alu_b_i[3:0]}) > 5'h0f))
      else $error("nibble carry wrong after add");

   user_flags_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      quiet_sfr |=> $stable(status_o.user_flag_zero) &&
                    $stable(status_o.user_flag_one))
      else $error("user flag changed without a write");

   bank_map_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      bank_base_o == {status_o.bank_select_high,
                      status_o.bank_select_low, 3'b000})
      else $error("bank base disagrees with bank select");

   add_ovf_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      alu_valid_i && alu_op_i == csp_pkg::CSP_OP_ADD &&
      alu_a_i[7] == alu_b_i[7] && chk_sum[7] != alu_a_i[7]
      |=> status_o.arith_excess_flag)
      else $error("signed overflow not flagged");

   mul_ovf_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      alu_valid_i && alu_op_i == csp_pkg::CSP_OP_MUL
      |=> status_o.arith_excess_flag == $past(chk_prod > 16'd255) &&
          !status_o.carry_flag)
      else $error("multiply overflow wrong");

   div_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      alu_valid_i && alu_op_i == csp_pkg::CSP_OP_DIV && alu_b_i == 8'h00
      |=> status_o.arith_excess_flag)
      else $error("divide by zero not flagged");

   ovf_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      alu_valid_i && alu_op_i == csp_pkg::CSP_OP_DIV && alu_b_i != 8'h00
      |=> !status_o.arith_excess_flag)
      else $error("overflow not cleared by divide");

   parity_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      1'b1 |=> status_o.parity == ^$past(acc_i))
      else $error("parity does not follow accumulator");

   bank_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      quiet_sfr [*2] |=> $stable(bank_base_o))
      else $error("bank moved without a status write");

   status_wr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      sfr_wr_i && sfr_addr_i == csp_pkg::SFR_STATUS_ADDR && !alu_valid_i
      |=> status_o[7:1] == $past(sfr_wdata_i[7:1]) &&
          status_o.parity == ^$past(acc_i))
      else $error("status write not applied");

endmodule : csp_core_regs

// ---- csp_core_regs_tb.sv ----
// Self-checking bench for the core status and pointer registers
`timescale 1ns/1ps
module csp_core_regs_tb;
   // Arithmetic case: operation, carry held before it, operands, {cy,ac,ov}
   typedef struct packed {
      csp_pkg::csp_arith_op_t op;
      logic                   cin;
      logic [7:0]             a;
      logic [7:0]             b;
      logic [2:0]             flags;
   } csp_row_t;

   // Design inputs, all given a value at time zero
   logic                   clk_i       = 1'b0;
   logic                   rst_n_i     = 1'b0;
   logic [7:0]             sfr_addr_i  = 8'h00;
   logic                   sfr_wr_i    = 1'b0;
   logic [7:0]             sfr_wdata_i = 8'h00;
   logic                   sfr_rd_i    = 1'b0;
   logic                   alu_valid_i = 1'b0;
   csp_pkg::csp_arith_op_t alu_op_i    = csp_pkg::CSP_OP_ADD;
   logic [7:0]             alu_a_i     = 8'h00;
   logic [7:0]             alu_b_i     = 8'h00;
   logic [7:0]             acc_i       = 8'h00;
   logic                   push_i      = 1'b0;
   logic                   pop_i       = 1'b0;
   // Design outputs
   logic [7:0]             sfr_rdata_o;
   logic [7:0]             stack_addr_o;
   logic [7:0]             stack_ptr_o;
   logic [15:0]            data_pointer_o;
   logic [4:0]             bank_base_o;
   csp_pkg::csp_status_t   status_o;
   // Bookkeeping
   int                     bad_count   = 0;
   int                     check_count = 0;
   csp_row_t               rows [13];
   logic [8:0]             par [4];

   // 40 MHz system clock
   always #12.5 clk_i = ~clk_i;

   csp_core_regs dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i),
      .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i),
      .sfr_rdata_o(sfr_rdata_o), .alu_valid_i(alu_valid_i),
      .alu_op_i(alu_op_i), .alu_a_i(alu_a_i), .alu_b_i(alu_b_i),
      .acc_i(acc_i), .push_i(push_i), .pop_i(pop_i),
      .stack_addr_o(stack_addr_o), .stack_ptr_o(stack_ptr_o),
      .data_pointer_o(data_pointer_o), .bank_base_o(bank_base_o),
      .status_o(status_o)
   );

   // Compare and count; four-state equality so unknowns never match
   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         bad_count++;
      end
   endtask : chk

   task automatic done_test(input string name);
      $display("test %s done", name);
   endtask : done_test

   // One-cycle write strobe; returns mid-cycle so outputs have settled
   task automatic sfr_wr(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clk_i);
      sfr_addr_i  <= addr;
      sfr_wdata_i <= data;
      sfr_wr_i    <= 1'b1;
      @(posedge clk_i);
      sfr_wr_i    <= 1'b0;
      @(negedge clk_i);
   endtask : sfr_wr

   task automatic sfr_rd(input logic [7:0] addr, input logic [7:0] exp);
      @(posedge clk_i);
      sfr_addr_i <= addr;
      sfr_rd_i   <= 1'b1;
      @(posedge clk_i);
      sfr_rd_i   <= 1'b0;
      @(negedge clk_i);
      chk("read data", {8'h00, exp}, {8'h00, sfr_rdata_o});
   endtask : sfr_rd

   task automatic alu(input csp_pkg::csp_arith_op_t op,
                      input logic [7:0] a, input logic [7:0] b);
      @(posedge clk_i);
      alu_op_i    <= op;
      alu_a_i     <= a;
      alu_b_i     <= b;
      alu_valid_i <= 1'b1;
      @(posedge clk_i);
      alu_valid_i <= 1'b0;
      @(negedge clk_i);
   endtask : alu

   // Pop reports the old pointer as its address, push the new one
   task automatic stk(input logic push, input logic pop,
                      input logic [7:0] ptr, input logic [7:0] addr);
      @(posedge clk_i);
      push_i <= push;
      pop_i  <= pop;
      @(posedge clk_i);
      push_i <= 1'b0;
      pop_i  <= 1'b0;
      @(negedge clk_i);
      chk("stack pointer", {8'h00, ptr}, {8'h00, stack_ptr_o});
      chk("stack address", {8'h00, addr}, {8'h00, stack_addr_o});
   endtask : stk

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : give_verdict

   // Guard against a hung run
   initial begin
      repeat (5000) @(posedge clk_i);
      $display("ERROR run length expected finish seen timeout");
      bad_count++;
      give_verdict();
   end

   initial begin
      // Carry preset to 1 where the op ignores it, so clearing is seen
      rows[0]  = '{csp_pkg::CSP_OP_ADD,  1'b1, 8'hff, 8'h01, 3'b110};
      rows[1]  = '{csp_pkg::CSP_OP_ADD,  1'b1, 8'h7f, 8'h01, 3'b011};
      rows[2]  = '{csp_pkg::CSP_OP_ADD,  1'b1, 8'h12, 8'h34, 3'b000};
      rows[3]  = '{csp_pkg::CSP_OP_ADDC, 1'b1, 8'h0f, 8'h00, 3'b010};
      rows[4]  = '{csp_pkg::CSP_OP_ADDC, 1'b1, 8'h80, 8'h7f, 3'b110};
      rows[5]  = '{csp_pkg::CSP_OP_ADDC, 1'b1, 8'h80, 8'h80, 3'b101};
      rows[6]  = '{csp_pkg::CSP_OP_SUBB, 1'b0, 8'h00, 8'h01, 3'b110};
      rows[7]  = '{csp_pkg::CSP_OP_SUBB, 1'b1, 8'h80, 8'h00, 3'b011};
      rows[8]  = '{csp_pkg::CSP_OP_SUBB, 1'b0, 8'h55, 8'h11, 3'b000};
      rows[9]  = '{csp_pkg::CSP_OP_MUL,  1'b1, 8'h10, 8'h10, 3'b001};
      rows[10] = '{csp_pkg::CSP_OP_MUL,  1'b1, 8'h0f, 8'h11, 3'b000};
      rows[11] = '{csp_pkg::CSP_OP_DIV,  1'b1, 8'h20, 8'h00, 3'b001};
      rows[12] = '{csp_pkg::CSP_OP_DIV,  1'b1, 8'h20, 8'h03, 3'b000};
      par = '{9'h101, 9'h003, 9'h180, 9'h0ff};
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(negedge clk_i);
      chk("stack pointer", 16'h0007, {8'h00, stack_ptr_o});
      chk("data pointer", 16'h0000, data_pointer_o);
      chk("status", 16'h0000, {8'h00, status_o});
      sfr_rd(csp_pkg::SFR_STACK_ADDR, 8'h07);
      done_test("reset values");
      // Nibble and overflow flags preset to 1 so each clear is visible
      for (int i = 0; i < 13; i++) begin
         // Only defined status bits are ever written as one
         sfr_wr(csp_pkg::SFR_STATUS_ADDR, rows[i].cin ? 8'hc4 : 8'h44);
         alu(rows[i].op, rows[i].a, rows[i].b);
         chk("flags", {13'h0000, rows[i].flags}, {13'h0000,
             status_o.carry_flag, status_o.nibble_carry_flag,
             status_o.arith_excess_flag});
      end
      done_test("arithmetic flags");
      // Bit 0 written as 1 must not stick
      for (int k = 0; k < 4; k++) begin
         sfr_wr(csp_pkg::SFR_STATUS_ADDR, 8'h23 | 8'(k << 3));
         chk("bank base", 16'(k * 8), {11'h000, bank_base_o});
         chk("status", 16'(8'h22 | (k << 3)), {8'h00, status_o});
      end
      alu(csp_pkg::CSP_OP_ADD, 8'h12, 8'h34);
      chk("status", 16'h003a, {8'h00, status_o});
      sfr_rd(csp_pkg::SFR_STATUS_ADDR, 8'h3a);
      done_test("user flags and banks");
      for (int j = 0; j < 4; j++) begin
         @(posedge clk_i);
         acc_i <= par[j][7:0];
         @(posedge clk_i);
         @(negedge clk_i);
         chk("parity", {15'h0000, par[j][8]}, {15'h0000, status_o.parity});
      end
      done_test("parity");
      sfr_wr(csp_pkg::SFR_DATA_POINTER_PAIR_HI, 8'h12);
      sfr_wr(csp_pkg::SFR_DATA_POINTER_PAIR_LO, 8'h34);
      chk("data pointer", 16'h1234, data_pointer_o);
      sfr_wr(8'h84, 8'hff);
      chk("data pointer", 16'h1234, data_pointer_o);
      sfr_rd(csp_pkg::SFR_DATA_POINTER_PAIR_HI, 8'h12);
      sfr_rd(8'h84, csp_pkg::UNMAPPED_READ);
      done_test("data pointer");
      stk(1'b1, 1'b0, 8'h08, 8'h08);
      stk(1'b1, 1'b0, 8'h09, 8'h09);
      stk(1'b0, 1'b1, 8'h08, 8'h09);
      stk(1'b1, 1'b1, 8'h09, 8'h09);
      sfr_wr(csp_pkg::SFR_STACK_ADDR, 8'hff);
      stk(1'b1, 1'b0, 8'h00, 8'h00);
      done_test("stack");
      // Asynchronous reset in mid-run
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      @(negedge clk_i);
      chk("stack pointer", 16'h0007, {8'h00, stack_ptr_o});
      chk("data pointer", 16'h0000, data_pointer_o);
      chk("status", 16'h0000, {8'h00, status_o});
      @(posedge clk_i);
      rst_n_i <= 1'b1;
      stk(1'b1, 1'b0, 8'h08, 8'h08);
      done_test("second reset");
      give_verdict();
   end
endmodule : csp_core_regs_tb
